// File: common/pmc_params.svh
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

`define PMC_MAX_AXES 6

// APB byte offsets
`define PMC_OFF_CMD 8'h00
`define PMC_OFF_ARG 8'h04
`define PMC_OFF_AUX 8'h08
`define PMC_OFF_STAT 8'h0C
`define PMC_OFF_LAST 8'h10
`define PMC_OFF_IRQ_ST 8'h14
`define PMC_OFF_IRQ_MSK 8'h18
`define PMC_OFF_ERR_CLR 8'h1C
`define PMC_AX_PAGE 3'h1

// CMD register fields
`define PMC_CMD_LSB 0
`define PMC_AXIS_LSB 4
`define PMC_SLOT_LSB 8
`define PMC_NV_BIT 12
`define PMC_SLOT_ID 4'h1
`define PMC_STORE_NV 1'h1

// Interrupt status bits
`define PMC_IRQ_REJ 0
`define PMC_IRQ_ACC 1
`define PMC_IRQ_DONE 2

// Error codes
`define PMC_E_JOG_RDY 16'h019D
`define PMC_E_INCH_BUSY 16'h0191
`define PMC_E_INCH_RDY 16'h0193
`define PMC_E_RET_BUSY 16'h01AF
`define PMC_E_RET_RDY 16'h01B2
`define PMC_E_PAR_RUN 16'h01D7
`define PMC_E_BAD_SLOT 16'h0E01
`define PMC_E_BAD_AXIS 16'h0E02
`define PMC_E_BAD_CMD 16'h0E03
`define PMC_E_NONE 16'h0000

`endif

// File: common/pmc_pkg.sv
package pmc_pkg;

    typedef enum {PMC_IDLE, PMC_EXEC} pmc_fsm_t;

    typedef enum logic [3:0] {
        PMC_C_JOG = 4'h1,
        PMC_C_JOG_STOP = 4'h2,
        PMC_C_INCH = 4'h3,
        PMC_C_RET = 4'h4,
        PMC_C_PAR_A = 4'h5,
        PMC_C_PAR_HOME = 4'h6,
        PMC_C_PAR_MAN = 4'h7,
        PMC_C_PAR_B = 4'h8,
        PMC_C_PAR_COMMON = 4'h9,
        PMC_C_PAR_IO = 4'hA,
        PMC_C_OPDATA = 4'hB
    } pmc_cmd_t;

    typedef enum logic [1:0] {
        PMC_MV_JOG = 2'h0,
        PMC_MV_STOP = 2'h1,
        PMC_MV_INCH = 2'h2,
        PMC_MV_RET = 2'h3
    } pmc_mv_t;

    typedef struct packed {
        logic valid;
        pmc_mv_t kind;
        logic [2:0] axis;
        logic fwd;
        logic fast;
        logic [31:0] amount;
    } pmc_mreq_t;

    typedef struct packed {
        logic valid;
        pmc_cmd_t group;
        logic [2:0] axis;
        logic [15:0] item;
        logic [31:0] value;
        logic nv;
    } pmc_pw_t;

endpackage

// File: rtl/pmc_cmd_checker.sv
//------------------------------------------------------------
// Contract
// - jog condition off gives reverse low-speed jog; on gives forward high-speed.
// - jog-active flag set while jogging; jog reconfig accepted while jogging.
// - jog on axis without drive ready is refused with code 413.
// - inching on an already inching axis is refused with code 401.
// - inching on axis without drive ready is refused with code 403.
// - accepted inching moves exactly the supplied amount, then stops.
// - return command while manual operation active is refused with 431.
// - return command on axis without drive ready is refused with 434.
// - accepted return drives axis to its position before manual moves.
// - axis operand is 1 to 6, or 1 to 2 on reduced variant.
// - parameter setting while operating refused with 471, except common and I/O parameters.
// - I/O parameter setting uses the value directly, no item selector.
// - storage selector 1 means non-volatile, 0 means volatile.
// - operating data accepted while running, applied after current step ends.
// - per-axis inching-active flag held while inching motion runs.
//------------------------------------------------------------
`include "pmc_params.svh"

module pmc_cmd_checker
    import pmc_pkg::*;
#(
    parameter int NUM_AXES = `PMC_MAX_AXES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`PMC_MAX_AXES-1:0] drive_ready,
    input wire logic jog_cond,
    input wire logic [`PMC_MAX_AXES-1:0] operating,
    input wire logic [`PMC_MAX_AXES-1:0] step_done,
    input wire logic [`PMC_MAX_AXES-1:0] motion_done,
    input wire logic [`PMC_MAX_AXES-1:0][31:0] axis_pos,
    output pmc_mreq_t mreq,
    output pmc_pw_t pw,
    output logic [`PMC_MAX_AXES-1:0] jog_active,
    output logic [`PMC_MAX_AXES-1:0] inch_active,
    output logic [`PMC_MAX_AXES-1:0] return_active,
    output logic [`PMC_MAX_AXES-1:0] axis_error,
    output logic irq
);

    typedef struct packed {
        pmc_fsm_t fsm;
        logic ack;
        logic slverr;
        logic [31:0] rdata;
        logic [31:0] cmd;
        logic [31:0] arg;
        logic [31:0] aux;
        logic [`PMC_MAX_AXES-1:0] rdy_m;
        logic [`PMC_MAX_AXES-1:0] rdy_s;
        logic jc_m;
        logic jc_s;
        logic [`PMC_MAX_AXES-1:0] jog;
        logic [`PMC_MAX_AXES-1:0] inch;
        logic [`PMC_MAX_AXES-1:0] ret;
        logic [`PMC_MAX_AXES-1:0] man;
        logic [`PMC_MAX_AXES-1:0] err;
        logic [15:0] last;
        logic [`PMC_MAX_AXES-1:0][15:0] ecode;
        logic [`PMC_MAX_AXES-1:0][31:0] home;
        logic [`PMC_MAX_AXES-1:0] od_pend;
        logic [`PMC_MAX_AXES-1:0][31:0] od_val;
        logic [`PMC_MAX_AXES-1:0][15:0] od_item;
        logic [`PMC_MAX_AXES-1:0] od_nv;
        logic [2:0] irq_st;
        logic [2:0] irq_msk;
        pmc_mreq_t mreq;
        pmc_pw_t pw;
    } pmc_state_t;

    pmc_state_t st;
    pmc_state_t next_st;
    pmc_cmd_t cop;
    logic [2:0] axf;
    logic [2:0] ai;
    logic ax_ok;
    logic slot_ok;
    logic nv;
    logic [15:0] code;
    logic [31:0] rd;
    logic hit;
    logic taken;
    logic [2:0] ev;
    logic [2:0] irq_clr;
    logic [`PMC_MAX_AXES-1:0] err_clr;
    logic [`PMC_MAX_AXES-1:0] err_set;

    assign cop = pmc_cmd_t'(st.cmd[`PMC_CMD_LSB +: 4]);
    assign axf = st.cmd[`PMC_AXIS_LSB +: 3];
    assign ai = axf - 3'h1;
    assign nv = st.cmd[`PMC_NV_BIT] == `PMC_STORE_NV;
    assign slot_ok = st.cmd[`PMC_SLOT_LSB +: 4] == `PMC_SLOT_ID;
    assign ax_ok = slot_ok && axf != 3'h0 && axf <= 3'(NUM_AXES);

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------
    always_comb begin
        next_st = st;
        code = `PMC_E_NONE;
        rd = 32'h0000_0000;
        hit = 1'b0;
        taken = 1'b0;
        ev = 3'h0;
        irq_clr = 3'h0;
        err_clr = '0;
        err_set = '0;
        next_st.mreq.valid = 1'b0;
        next_st.pw.valid = 1'b0;
        next_st.rdy_m = drive_ready;
        next_st.rdy_s = st.rdy_m;
        next_st.jc_m = jog_cond;
        next_st.jc_s = st.jc_m;

        // Motion engine reports end of inching or return
        for (int i = 0; i < `PMC_MAX_AXES; i++) begin
            if (motion_done[i]) begin
                next_st.inch[i] = 1'b0;
                if (st.ret[i]) begin
                    next_st.ret[i] = 1'b0;
                    next_st.man[i] = 1'b0;
                end
                ev[`PMC_IRQ_DONE] = 1'b1;
            end
        end

        // Held operating data; idle axis counts as step finished
        if (st.fsm != PMC_EXEC) begin
            for (int i = 0; i < `PMC_MAX_AXES; i++) begin
                if (!taken && st.od_pend[i] && (step_done[i] || !operating[i])) begin
                    taken = 1'b1;
                    next_st.od_pend[i] = 1'b0;
                    next_st.pw = '{1'b1, PMC_C_OPDATA, 3'(i), st.od_item[i],
                                   st.od_val[i], st.od_nv[i]};
                end
            end
        end

        //------------------------------------------------------------
        // APB slave: one wait state, read data from flops
        //------------------------------------------------------------
        case (paddr)
            `PMC_OFF_CMD: begin
                rd = st.cmd;
                hit = 1'b1;
            end
            `PMC_OFF_ARG: begin
                rd = st.arg;
                hit = 1'b1;
            end
            `PMC_OFF_AUX: begin
                rd = st.aux;
                hit = 1'b1;
            end
            `PMC_OFF_STAT: begin
                rd = {st.fsm == PMC_EXEC, 1'b0, st.err, 2'h0, st.ret,
                      2'h0, st.inch, 2'h0, st.jog};
                hit = 1'b1;
            end
            `PMC_OFF_LAST: begin
                rd = {16'h0000, st.last};
                hit = 1'b1;
            end
            `PMC_OFF_IRQ_ST: begin
                rd = {29'h0, st.irq_st};
                hit = 1'b1;
            end
            `PMC_OFF_IRQ_MSK: begin
                rd = {29'h0, st.irq_msk};
                hit = 1'b1;
            end
            `PMC_OFF_ERR_CLR: begin
                hit = 1'b1;
            end
            default: begin
                if (paddr[7:5] == `PMC_AX_PAGE && paddr[1:0] == 2'h0 &&
                    paddr[4:2] < 3'(NUM_AXES)) begin
                    rd = {16'h0000, st.ecode[paddr[4:2]]};
                    hit = 1'b1;
                end
            end
        endcase

        if (psel && penable && !st.ack) begin
            next_st.ack = 1'b1;
            next_st.rdata = rd;
            next_st.slverr = !hit;
        end else if (psel && penable) begin
            next_st.ack = 1'b0;
            next_st.slverr = 1'b0;
            if (pwrite && !st.slverr) begin
                case (paddr)
                    `PMC_OFF_CMD: begin
                        next_st.cmd = pwdata;
                        next_st.fsm = PMC_EXEC;
                    end
                    `PMC_OFF_ARG: next_st.arg = pwdata;
                    `PMC_OFF_AUX: next_st.aux = pwdata;
                    `PMC_OFF_IRQ_ST: irq_clr = pwdata[2:0];
                    `PMC_OFF_IRQ_MSK: next_st.irq_msk = pwdata[2:0];
                    `PMC_OFF_ERR_CLR: err_clr = pwdata[`PMC_MAX_AXES-1:0];
                    default: ;
                endcase
            end
        end

        //------------------------------------------------------------
        // Command check and launch
        //------------------------------------------------------------
        // Error flag is reported, never used to block: gating is the
        // commander's choice
        if (st.fsm == PMC_EXEC) begin
            next_st.fsm = PMC_IDLE;
            if (!slot_ok) begin
                code = `PMC_E_BAD_SLOT;
            end else if (!ax_ok) begin
                code = `PMC_E_BAD_AXIS;
            end else begin
                case (cop)
                    PMC_C_JOG: begin
                        if (!st.rdy_s[ai]) begin
                            code = `PMC_E_JOG_RDY;
                        end else begin
                            next_st.jog[ai] = 1'b1;
                            next_st.mreq = '{1'b1, PMC_MV_JOG, ai, st.jc_s,
                                             st.jc_s, 32'h0};
                        end
                    end
                    PMC_C_JOG_STOP: begin
                        next_st.jog[ai] = 1'b0;
                        next_st.mreq = '{1'b1, PMC_MV_STOP, ai, 1'b0, 1'b0, 32'h0};
                    end
                    PMC_C_INCH: begin
                        if (st.inch[ai]) begin
                            code = `PMC_E_INCH_BUSY;
                        end else if (!st.rdy_s[ai]) begin
                            code = `PMC_E_INCH_RDY;
                        end else begin
                            next_st.inch[ai] = 1'b1;
                            next_st.mreq = '{1'b1, PMC_MV_INCH, ai, 1'b0,
                                             1'b0, st.arg};
                        end
                    end
                    PMC_C_RET: begin
                        if (st.jog[ai] || st.inch[ai] || st.ret[ai]) begin
                            code = `PMC_E_RET_BUSY;
                        end else if (!st.rdy_s[ai]) begin
                            code = `PMC_E_RET_RDY;
                        end else begin
                            next_st.ret[ai] = 1'b1;
                            // Without manual moves, home is the current spot
                            next_st.mreq = '{1'b1, PMC_MV_RET, ai, 1'b0, 1'b0,
                                             st.man[ai] ? st.home[ai]
                                                        : axis_pos[ai]};
                        end
                    end
                    PMC_C_PAR_A, PMC_C_PAR_HOME, PMC_C_PAR_MAN, PMC_C_PAR_B: begin
                        if (operating[ai]) begin
                            code = `PMC_E_PAR_RUN;
                        end else begin
                            next_st.pw = '{1'b1, cop, ai, st.aux[15:0], st.arg, nv};
                        end
                    end
                    PMC_C_PAR_COMMON: begin
                        next_st.pw = '{1'b1, cop, ai, st.aux[15:0], st.arg, nv};
                    end
                    PMC_C_PAR_IO: begin
                        next_st.pw = '{1'b1, cop, ai, 16'h0000, st.arg, nv};
                    end
                    PMC_C_OPDATA: begin
                        if (operating[ai]) begin
                            next_st.od_pend[ai] = 1'b1;
                            next_st.od_val[ai] = st.arg;
                            next_st.od_item[ai] = st.aux[15:0];
                            next_st.od_nv[ai] = nv;
                        end else begin
                            next_st.pw = '{1'b1, cop, ai, st.aux[15:0], st.arg, nv};
                        end
                    end
                    default: code = `PMC_E_BAD_CMD;
                endcase
                // Pre-manual position caught at the first manual move only
                if (code == `PMC_E_NONE && (cop == PMC_C_JOG || cop == PMC_C_INCH) &&
                    !st.man[ai]) begin
                    next_st.man[ai] = 1'b1;
                    next_st.home[ai] = axis_pos[ai];
                end
            end
            if (code != `PMC_E_NONE) begin
                next_st.last = code;
                ev[`PMC_IRQ_REJ] = 1'b1;
                if (ax_ok) begin
                    err_set[ai] = 1'b1;
                    next_st.ecode[ai] = code;
                end
            end else begin
                ev[`PMC_IRQ_ACC] = 1'b1;
            end
        end

        // Setting beats a clear in the same cycle
        next_st.err = (st.err & ~err_clr) | err_set;
        next_st.irq_st = (st.irq_st & ~irq_clr) | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pready = st.ack;
    assign prdata = st.rdata;
    assign pslverr = st.slverr;
    assign mreq = st.mreq;
    assign pw = st.pw;
    assign jog_active = st.jog;
    assign inch_active = st.inch;
    assign return_active = st.ret;
    assign axis_error = st.err;
    assign irq = |(st.irq_st & st.irq_msk);

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic ex;
    assign ex = st.fsm == PMC_EXEC && ax_ok;

    sequence s_rej(logic [15:0] c);
        ##1 (!st.mreq.valid && st.last == c && st.err[ai]);
    endsequence

    sequence s_move(pmc_mv_t k);
        ##1 (st.mreq.valid && st.mreq.kind == k && st.mreq.axis == ai);
    endsequence

    jog_dir_a: assert property ((st.mreq.valid && st.mreq.kind == PMC_MV_JOG) |->
        (st.mreq.fwd == $past(st.jc_s) && st.mreq.fast == $past(st.jc_s)))
        else $error("jog direction or speed mismatch");
    jog_flag_a: assert property ((ex && cop == PMC_C_JOG && st.rdy_s[ai]) |->
        s_move(PMC_MV_JOG) ##0 st.jog[ai])
        else $error("jog not started or flag low");
    jog_ready_a: assert property ((ex && cop == PMC_C_JOG && !st.rdy_s[ai]) |->
        s_rej(`PMC_E_JOG_RDY))
        else $error("jog without ready not refused");
    inch_busy_a: assert property ((ex && cop == PMC_C_INCH && st.inch[ai]) |->
        s_rej(`PMC_E_INCH_BUSY))
        else $error("inching while inching not refused");
    inch_ready_a: assert property ((ex && cop == PMC_C_INCH && !st.inch[ai] &&
        !st.rdy_s[ai]) |-> s_rej(`PMC_E_INCH_RDY))
        else $error("inching without ready not refused");
    inch_amount_a: assert property ((ex && cop == PMC_C_INCH && !st.inch[ai] &&
        st.rdy_s[ai]) |-> s_move(PMC_MV_INCH) ##0 (st.mreq.amount == st.arg))
        else $error("inching amount wrong");
    ret_busy_a: assert property ((ex && cop == PMC_C_RET &&
        (st.jog[ai] || st.inch[ai] || st.ret[ai])) |-> s_rej(`PMC_E_RET_BUSY))
        else $error("return while manual not refused");
    ret_ready_a: assert property ((ex && cop == PMC_C_RET && !st.jog[ai] &&
        !st.inch[ai] && !st.ret[ai] && !st.rdy_s[ai]) |-> s_rej(`PMC_E_RET_RDY))
        else $error("return without ready not refused");
    ret_pos_a: assert property ((st.mreq.valid && st.mreq.kind == PMC_MV_RET &&
        st.man[st.mreq.axis]) |-> st.mreq.amount == st.home[st.mreq.axis])
        else $error("return target is not pre-manual position");
    param_run_a: assert property ((ex && operating[ai] && (cop == PMC_C_PAR_A ||
        cop == PMC_C_PAR_B || cop == PMC_C_PAR_HOME || cop == PMC_C_PAR_MAN)) |->
        s_rej(`PMC_E_PAR_RUN) ##0 !st.pw.valid)
        else $error("parameter write while running not refused");
    opdata_hold_a: assert property ((ex && cop == PMC_C_OPDATA && operating[ai]) |=>
        (st.od_pend[ai] && !st.pw.valid))
        else $error("operating data not held while running");
    inch_flag_a: assert property ((st.mreq.valid && st.mreq.kind == PMC_MV_INCH) |->
        st.inch[st.mreq.axis])
        else $error("inching flag low during inching");
    reject_a: assert property ((st.fsm == PMC_EXEC && code != `PMC_E_NONE) |=>
        (!st.mreq.valid && !st.pw.valid && st.irq_st[`PMC_IRQ_REJ]))
        else $error("rejected command started motion");

endmodule // pmc_cmd_checker

// File: test/pmc_axis_model.sv
// ------------------------------
// Axis motion stand-in
// ------------------------------
module pmc_axis_model
    import pmc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire pmc_mreq_t mreq,
    input wire logic [7:0] lag,
    input wire logic [5:0] run_prog,
    input wire logic [5:0] step_end,
    output logic [5:0] operating,
    output logic [5:0] step_done,
    output logic [5:0] motion_done,
    output logic [5:0][31:0] axis_pos
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] jog;
    logic [5:0] mov;
    logic [5:0][31:0] tgt;
    logic [5:0][7:0] cnt;
    assign operating = jog | mov | run_prog;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jog <= '0;
            mov <= '0;
            tgt <= '0;
            cnt <= '0;
            step_done <= '0;
            motion_done <= '0;
            // Distinct start points so a stale return target shows
            for (int i = 0; i < 6; i++) begin
                axis_pos[i] <= 32'(4096 * (i + 1));
            end
        end else begin
            motion_done <= '0;
            step_done <= step_end & run_prog;
            for (int i = 0; i < 6; i++) begin
                if (mov[i] && cnt[i] == 8'h00) begin
                    mov[i] <= 1'b0;
                    axis_pos[i] <= tgt[i];
                    motion_done[i] <= 1'b1;
                end else if (mov[i]) begin
                    cnt[i] <= cnt[i] - 8'h01;
                end
            end
            if (mreq.valid) begin
                case (mreq.kind)
                    PMC_MV_JOG: jog[mreq.axis] <= 1'b1;
                    PMC_MV_STOP: jog[mreq.axis] <= 1'b0;
                    default: begin
                        mov[mreq.axis] <= 1'b1;
                        cnt[mreq.axis] <= lag;
                        tgt[mreq.axis] <= (mreq.kind == PMC_MV_INCH) ?
                            axis_pos[mreq.axis] + mreq.amount : mreq.amount;
                    end
                endcase
            end
        end
    end
endmodule // pmc_axis_model

// File: test/testbench.sv
`include "pmc_params.svh"

module testbench
    import pmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, irq, e;
    logic [5:0] drive_ready = 6'h3F;
    logic jog_cond = 1'b0;
    logic [5:0] run_prog = 6'h00;
    logic [5:0] step_end = 6'h00;
    logic [5:0] operating, step_done, motion_done;
    logic [5:0] jog_active, inch_active, return_active, axis_error;
    logic [5:0][31:0] axis_pos;
    pmc_mreq_t mreq, mseen;
    pmc_pw_t pw, pseen;
    int err_total = 0;
    int compares = 0;
    int mcount = 0;
    int mc0;

    always #4 pclk = ~pclk;

    pmc_cmd_checker #(.NUM_AXES(6)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .drive_ready(drive_ready), .jog_cond(jog_cond),
        .operating(operating), .step_done(step_done), .motion_done(motion_done),
        .axis_pos(axis_pos), .mreq(mreq), .pw(pw), .jog_active(jog_active),
        .inch_active(inch_active), .return_active(return_active), .axis_error(axis_error),
        .irq(irq));

    pmc_axis_model i_axes (.pclk(pclk), .presetn(presetn), .mreq(mreq), .lag(8'h60),
        .run_prog(run_prog), .step_end(step_end), .operating(operating),
        .step_done(step_done), .motion_done(motion_done), .axis_pos(axis_pos));

    // Requests are single-cycle pulses, so latch them as they pass
    always @(posedge pclk) begin
        if (mreq.valid === 1'b1) begin
            mseen <= mreq;
            mcount <= mcount + 1;
        end
        if (pw.valid === 1'b1) begin
            pseen <= pw;
        end
    end

    // ------------------------------
    // Shared tasks
    // ------------------------------
    task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tmo(input int n);
        if (n >= 200) begin
            err_total++;
            finish_test();
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 200);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tmo(n);
    endtask

    task automatic cmd(input pmc_cmd_t c, input int ax, input logic [31:0] v, input logic nv);
        if (axis_error[ax-1] !== 1'b0) begin
            apb(1, `PMC_OFF_ERR_CLR, 32'(1 << (ax - 1)));
        end
        apb(1, `PMC_OFF_ARG, v);
        mc0 = mcount;
        apb(1, `PMC_OFF_CMD, {19'h0, nv, `PMC_SLOT_ID, 1'b0, 3'(ax), c});
        repeat (3) @(posedge pclk);
    endtask

    task automatic rej(input int ax, input logic [15:0] code);
        apb(0, 8'(32 + 4 * (ax - 1)), 32'h0);
        chk("axis_code", q, code);
        chk("axis_error", axis_error[ax-1], 1'b1);
        chk("no_motion", mcount, mc0);
    endtask

    task automatic idle(input int ax);
        int n;
        n = 0;
        while ((inch_active[ax-1] | return_active[ax-1]) !== 1'b0 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        tmo(n);
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_jog;
        drive_ready <= 6'h3B;
        cmd(PMC_C_JOG, 1, 0, 0);
        chk("jog_rev", {mseen.kind, mseen.axis, mseen.fwd, mseen.fast}, {PMC_MV_JOG, 5'h00});
        chk("jog_flag", jog_active, 6'h01);
        jog_cond <= 1'b1;
        cmd(PMC_C_JOG, 1, 0, 0);
        chk("jog_fwd", {mseen.kind, mseen.fwd, mseen.fast, mcount}, {PMC_MV_JOG, 2'h3, mc0 + 1});
        cmd(PMC_C_JOG_STOP, 1, 0, 0);
        chk("jog_stop", jog_active, 6'h00);
        cmd(PMC_C_JOG, 3, 0, 0);
        rej(3, `PMC_E_JOG_RDY);
    endtask

    task automatic t_inch;
        cmd(PMC_C_INCH, 2, 32'h100, 0);
        chk("inch_req", {mseen.kind, mseen.axis, mseen.amount}, {PMC_MV_INCH, 3'h1, 32'h100});
        chk("inch_flag", inch_active, 6'h02);
        cmd(PMC_C_INCH, 2, 32'h100, 0);
        rej(2, `PMC_E_INCH_BUSY);
        cmd(PMC_C_RET, 2, 0, 0);
        rej(2, `PMC_E_RET_BUSY);
        idle(2);
        chk("inch_end", {inch_active, axis_pos[1]}, {6'h00, 32'h2100});
        cmd(PMC_C_RET, 2, 0, 0);
        chk("ret_req", {mseen.kind, mseen.amount, return_active}, {PMC_MV_RET, 32'h2000, 6'h02});
        idle(2);
        chk("ret_end", {return_active, axis_pos[1]}, {6'h00, 32'h2000});
        cmd(PMC_C_INCH, 3, 32'h10, 0);
        rej(3, `PMC_E_INCH_RDY);
        cmd(PMC_C_RET, 3, 0, 0);
        rej(3, `PMC_E_RET_RDY);
    endtask

    task automatic t_par;
        run_prog <= 6'h01;
        for (int k = 5; k <= 8; k++) begin
            cmd(pmc_cmd_t'(4'(k)), 1, 0, 0);
            rej(1, `PMC_E_PAR_RUN);
        end
        apb(1, `PMC_OFF_AUX, 32'h7);
        // First flash write of the run
        cmd(PMC_C_PAR_COMMON, 1, 32'h55, 1);
        chk("par_common", {pseen.group, pseen.item, pseen.value, pseen.nv}, {PMC_C_PAR_COMMON, 16'h7, 32'h55, 1'b1});
        cmd(PMC_C_PAR_IO, 1, 32'h1234, 0);
        chk("par_io", {pseen.group, pseen.item, pseen.value, pseen.nv}, {PMC_C_PAR_IO, 16'h0, 32'h1234, 1'b0});
        cmd(PMC_C_OPDATA, 1, 32'h77, 0);
        chk("op_held", pseen.value, 32'h1234);
        step_end <= 6'h01;
        @(posedge pclk);
        step_end <= 6'h00;
        repeat (4) @(posedge pclk);
        chk("op_apply", {pseen.group, pseen.axis, pseen.value}, {PMC_C_OPDATA, 3'h0, 32'h77});
        run_prog <= 6'h00;
    endtask

    task automatic t_irq;
        apb(1, `PMC_OFF_IRQ_ST, 32'h7);
        apb(1, `PMC_OFF_IRQ_MSK, 32'h1);
        @(posedge pclk);
        chk("irq_idle", irq, 1'b0);
        cmd(PMC_C_JOG, 3, 0, 0);
        chk("irq_set", irq, 1'b1);
        apb(0, `PMC_OFF_IRQ_ST, 0);
        chk("irq_st", q[2:0], 3'h1);
        apb(1, `PMC_OFF_IRQ_MSK, 32'h0);
        @(posedge pclk);
        chk("irq_mask", irq, 1'b0);
        apb(1, `PMC_OFF_IRQ_MSK, 32'h1);
        apb(1, `PMC_OFF_IRQ_ST, 32'h1);
        @(posedge pclk);
        chk("irq_w1c", irq, 1'b0);
        apb(0, 8'hFC, 0);
        chk("unmapped", {e, q}, {1'b1, 32'h0});
    endtask

    task automatic t_bad;
        mc0 = mcount;
        apb(1, `PMC_OFF_CMD, {19'h0, 1'b0, 4'h2, 1'b0, 3'h1, PMC_C_JOG});
        repeat (3) @(posedge pclk);
        apb(0, `PMC_OFF_LAST, 0);
        chk("bad_slot", {q, mcount}, {16'h0000, `PMC_E_BAD_SLOT, mc0});
        apb(1, `PMC_OFF_CMD, {19'h0, 1'b0, `PMC_SLOT_ID, 1'b0, 3'h7, PMC_C_JOG});
        repeat (3) @(posedge pclk);
        apb(0, `PMC_OFF_LAST, 0);
        chk("bad_axis", {q, mcount}, {16'h0000, `PMC_E_BAD_AXIS, mc0});
        cmd(pmc_cmd_t'(4'hF), 2, 0, 0);
        rej(2, `PMC_E_BAD_CMD);
        cmd(PMC_C_OPDATA, 2, 32'h99, 1);
        chk("op_idle", {pseen.group, pseen.axis, pseen.value, pseen.nv}, {PMC_C_OPDATA, 3'h1, 32'h99, 1'b1});
    endtask

    task automatic finish_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `PMC_OFF_STAT, 0);
        chk("stat_rst", q, 32'h0);
        t_jog();
        t_inch();
        t_par();
        t_irq();
        t_bad();
        finish_test();
    end
endmodule // testbench
